// ===== inc/dms_pkg.sv
/*
 * dms_pkg: constants shared by the diagnostic selector device end, its
 * host controller end and the link between them.
 * Assumes a single 100 MHz clock and 8-bit registers on the link.
 */
package dms_pkg;
    localparam int NUM_CH = 8;
    localparam int SEL_W = 3;
    localparam int RNG_W = 4;
    localparam int LADDR_W = 6;
    localparam int LDATA_W = 8;
    localparam int OSP_W = 3;
    localparam int OSR_W = 4;

    // device register map (link addresses)
    localparam logic [5:0] DEV_RANGE_FIRST = 6'h03;
    localparam logic [5:0] DEV_RANGE_LAST = 6'h06;
    localparam logic [5:0] DEV_OVERSAMPLE = 6'h08;
    localparam logic [5:0] DEV_DIAG_A = 6'h28;
    localparam logic [5:0] DEV_DIAG_D = 6'h2B;
    localparam logic [7:0] DEV_RANGE_RST = 8'h33;
    localparam logic [7:0] DEV_OS_RST = 8'h00;
    localparam logic [7:0] DEV_DIAG_RST = 8'h00;

    // two channels per 8-bit register: low channel at 0, high at 4
    localparam int HALF_POS = 4;
    localparam logic [3:0] OS_RATIO_MASK = 4'hF;

    // range codes
    localparam logic [3:0] RNG_10V = 4'h3;
    localparam logic [3:0] RNG_5V = 4'h2;

    // selector codes
    localparam logic [2:0] SEL_EXT = 3'h0;
    localparam logic [2:0] SEL_TEMP = 3'h1;
    localparam logic [2:0] SEL_REF = 3'h2;
    localparam logic [2:0] SEL_ANALOG_REG = 3'h3;
    localparam logic [2:0] SEL_DIGITAL_REG = 3'h4;
    localparam logic [2:0] SEL_LOGIC_SUPPLY = 3'h5;
    localparam logic [2:0] SEL_ANALOG_GND = 3'h6;
    localparam logic [2:0] SEL_ANALOG_SUPPLY = 3'h7;

    // host APB register map
    localparam logic [11:0] HR_CTRL = 12'h000;
    localparam logic [11:0] HR_CMD = 12'h004;
    localparam logic [11:0] HR_STATUS = 12'h008;
    // CTRL fields
    localparam int CTRL_REF_SEL = 0;
    localparam int CTRL_IFACE_SEL = 1;
    localparam int CTRL_RANGE_PIN = 2;
    localparam int CTRL_OS_LSB = 4;
    localparam int CTRL_FULL_RST = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0003;
    // CMD fields
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WRITE = 16;
    // STATUS fields
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_RANGE_VIOL = 2;
    localparam int ST_RDATA_LSB = 8;

    // full reset pulse on the link
    localparam int CLK_PERIOD_NS = 10;
    localparam int FULL_RST_NS = 100;
    localparam int FULL_RST_CYC = (FULL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRC_W = 8;
endpackage : dms_pkg

// ===== inc/dms_link.sv
/*
 * dms_link: register port and configuration pins between the host
 * controller and the diagnostic selector device.
 * Assumes both ends run on the same clock; no clocking block.
 */
`timescale 1ns/1ps
interface dms_link;
    import dms_pkg::*;
    logic req;
    logic wr;
    logic [LADDR_W-1:0] addr;
    logic [LDATA_W-1:0] wdata;
    logic [LDATA_W-1:0] rdata;
    logic ack;
    logic err;
    logic full_rst;
    logic ref_sel;
    logic iface_sel;
    logic [OSP_W-1:0] os_pins;
    logic range_pin;

    modport dev (
        input req, wr, addr, wdata, full_rst, ref_sel, iface_sel, os_pins, range_pin,
        output rdata, ack, err
    );
    modport host (
        output req, wr, addr, wdata, full_rst, ref_sel, iface_sel, os_pins, range_pin,
        input rdata, ack, err
    );
endinterface : dms_link

// ===== design/dms_device.sv
/*
 * dms_device: register bank and configuration-pin decode of an
 * eight-channel converter's diagnostic input selectors.
 * Assumes the host holds req until ack and drives the pins synchronously.
 */
`timescale 1ns/1ps
module dms_device (
    input wire logic ref_clk,
    input wire logic nrst,
    dms_link.dev lnk,
    output logic [dms_pkg::NUM_CH*dms_pkg::SEL_W-1:0] ch_sel,
    output logic [dms_pkg::NUM_CH-1:0] ch_ext_connect,
    output logic [dms_pkg::NUM_CH*dms_pkg::RNG_W-1:0] ch_range,
    output logic [dms_pkg::OSR_W-1:0] os_ratio,
    output logic sw_mode,
    output logic serial_mode,
    output logic parallel_mode,
    output logic int_ref_en,
    output logic diag_ref_internal
);
    import dms_pkg::*;

    localparam int NREG = NUM_CH / 2;

    logic [LDATA_W-1:0] range_r [NREG];
    logic [LDATA_W-1:0] diag_r [NREG];
    logic [LDATA_W-1:0] os_r;
    logic ack_r;
    logic err_r;
    logic [LDATA_W-1:0] rdata_r;
    logic [NUM_CH*SEL_W-1:0] ch_sel_r;
    logic [NUM_CH-1:0] ext_r;
    logic [NUM_CH*RNG_W-1:0] range_out_r;
    logic [OSR_W-1:0] os_ratio_r;
    logic sw_mode_r;
    logic serial_r;
    logic parallel_r;
    logic int_ref_r;
    logic diag_ref_r;

    logic sw_now;
    logic take;
    logic in_range;
    logic in_diag;
    logic is_os;
    logic mapped;
    logic refused;
    logic [1:0] ridx;
    logic [1:0] didx;
    logic [LDATA_W-1:0] rd_val;

    // all ratio pins high hands ranges and ratio over to the register map
    assign sw_now = &lnk.os_pins;
    // ack_r masks the cycle in which the host still shows the answered req
    assign take = lnk.req && !ack_r;
    assign in_range = lnk.addr >= DEV_RANGE_FIRST && lnk.addr <= DEV_RANGE_LAST;
    assign in_diag = lnk.addr >= DEV_DIAG_A && lnk.addr <= DEV_DIAG_D;
    assign is_os = lnk.addr == DEV_OVERSAMPLE;
    assign mapped = in_range || in_diag || is_os;
    assign ridx = 2'(lnk.addr - DEV_RANGE_FIRST);
    assign didx = 2'(lnk.addr - DEV_DIAG_A);
    // register port only exists on the serial interface
    assign refused = !lnk.iface_sel || !mapped || (lnk.wr && !sw_now);

    always_comb begin
        rd_val = '0;
        if (in_range) begin
            rd_val = range_r[ridx];
        end else if (in_diag) begin
            rd_val = diag_r[didx];
        end else if (is_os) begin
            rd_val = os_r;
        end
    end

    // link handshake: one ack per taken request, never in two consecutive cycles
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else if (lnk.full_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    // answer of a request; stands until the next one is taken or a full reset clears it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            err_r <= 1'b0;
            rdata_r <= '0;
        end else if (lnk.full_rst) begin
            err_r <= 1'b0;
            rdata_r <= '0;
        end else if (take) begin
            err_r <= refused;
            // refused reads give zero so stale map contents never leak out
            rdata_r <= (refused || lnk.wr) ? '0 : rd_val;
        end
    end

    // register bank; full reset restores defaults
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k < NREG; k++) begin
                range_r[k] <= DEV_RANGE_RST;
                diag_r[k] <= DEV_DIAG_RST;
            end
            os_r <= DEV_OS_RST;
        end else if (lnk.full_rst) begin
            for (int k = 0; k < NREG; k++) begin
                range_r[k] <= DEV_RANGE_RST;
                diag_r[k] <= DEV_DIAG_RST;
            end
            os_r <= DEV_OS_RST;
        end else if (take && lnk.wr && !refused) begin
            if (in_range) begin
                range_r[ridx] <= lnk.wdata;
            end else if (in_diag) begin
                diag_r[didx] <= lnk.wdata;
            end else begin
                os_r <= lnk.wdata;
            end
        end
    end

    // per-channel selector decode, registered onto the outputs
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam int RI = i / 2;
        localparam int POS = (i % 2) * HALF_POS;
        logic [SEL_W-1:0] sel;
        assign sel = diag_r[RI][POS +: SEL_W];

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                ch_sel_r[i*SEL_W +: SEL_W] <= SEL_EXT;
                ext_r[i] <= 1'b1;
                range_out_r[i*RNG_W +: RNG_W] <= RNG_10V;
            end else begin
                ch_sel_r[i*SEL_W +: SEL_W] <= sel;
                ext_r[i] <= sel == SEL_EXT;
                if (sw_now) begin
                    range_out_r[i*RNG_W +: RNG_W] <= range_r[RI][POS +: RNG_W];
                end else begin
                    range_out_r[i*RNG_W +: RNG_W] <= lnk.range_pin ? RNG_10V : RNG_5V;
                end
            end
        end
    end

    // operating mode and the oversampling ratio it selects
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sw_mode_r <= 1'b0;
            os_ratio_r <= '0;
        end else begin
            sw_mode_r <= sw_now;
            // hardware mode: ratio straight from the pins
            os_ratio_r <= sw_now ? (os_r[OSR_W-1:0] & OS_RATIO_MASK)
                                 : OSR_W'(lnk.os_pins);
        end
    end

    // data interface; both flags kept so each port mux has its own enable
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            serial_r <= 1'b0;
            parallel_r <= 1'b0;
        end else begin
            serial_r <= lnk.iface_sel;
            parallel_r <= !lnk.iface_sel;
        end
    end

    // reference source; the diagnostic node tracks the same pin
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            int_ref_r <= 1'b0;
            diag_ref_r <= 1'b0;
        end else begin
            int_ref_r <= lnk.ref_sel;
            diag_ref_r <= lnk.ref_sel;
        end
    end

    assign lnk.ack = ack_r;
    assign lnk.err = err_r;
    assign lnk.rdata = rdata_r;
    assign ch_sel = ch_sel_r;
    assign ch_ext_connect = ext_r;
    assign ch_range = range_out_r;
    assign os_ratio = os_ratio_r;
    assign sw_mode = sw_mode_r;
    assign serial_mode = serial_r;
    assign parallel_mode = parallel_r;
    assign int_ref_en = int_ref_r;
    assign diag_ref_internal = diag_ref_r;
endmodule : dms_device

// ===== design/dms_host.sv
/*
 * dms_host: APB-programmed controller that drives the configuration pins
 * and the register port of the diagnostic selector device.
 * Assumes the device acks every request on the link.
 */
`timescale 1ns/1ps
module dms_host (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dms_link.host lnk
);
    import dms_pkg::*;

    typedef enum logic [1:0] {ST_RST, ST_IDLE, ST_REQ} dms_state_e;

    dms_state_e state_r;
    logic [FRC_W-1:0] frc_r;
    logic [31:0] ctrl_r;
    logic req_r;
    logic wr_r;
    logic [LADDR_W-1:0] addr_r;
    logic [LDATA_W-1:0] wdata_r;
    logic refused_r;
    logic viol_r;
    logic [LDATA_W-1:0] rdata_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [RNG_W-1:0] shadow_r [NUM_CH];

    logic setup;
    logic wr_cmd;
    logic [LADDR_W-1:0] c_addr;
    logic [LDATA_W-1:0] c_data;
    logic c_viol;
    logic [2:0] c_ch;
    logic [31:0] status;

    assign setup = psel && !penable;
    assign wr_cmd = setup && pwrite && paddr == HR_CMD && state_r == ST_IDLE;
    assign c_addr = pwdata[CMD_ADDR_LSB +: LADDR_W];
    assign c_data = pwdata[CMD_WDATA_LSB +: LDATA_W];
    assign c_ch = 3'((c_addr - DEV_DIAG_A) * 2);
    // diagnostics only on channels known to be at the 10 V range
    assign c_viol = pwdata[CMD_WRITE] && c_addr >= DEV_DIAG_A && c_addr <= DEV_DIAG_D
        && ((c_data[SEL_W-1:0] != SEL_EXT && shadow_r[c_ch] != RNG_10V)
        || (c_data[HALF_POS +: SEL_W] != SEL_EXT && shadow_r[c_ch + 3'h1] != RNG_10V));
    assign status = {16'h0000, rdata_r, 5'h00, viol_r, refused_r, state_r != ST_IDLE};

    // APB: captured in setup, answered in the first access cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                pslverr_r <= !(paddr == HR_CTRL || paddr == HR_CMD || paddr == HR_STATUS);
                unique case (paddr)
                    HR_CTRL: prdata_r <= ctrl_r;
                    HR_STATUS: prdata_r <= status;
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RST;
        end else begin
            ctrl_r[CTRL_FULL_RST] <= 1'b0;
            if (setup && pwrite && paddr == HR_CTRL) begin
                ctrl_r <= pwdata;
            end
        end
    end

    // full reset after power-up and on request; command sequencer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RST;
            frc_r <= FRC_W'(FULL_RST_CYC);
            req_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            refused_r <= 1'b0;
            viol_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            unique case (state_r)
                ST_RST: begin
                    frc_r <= frc_r - FRC_W'(1);
                    if (frc_r == FRC_W'(1)) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (ctrl_r[CTRL_FULL_RST]) begin
                        state_r <= ST_RST;
                        frc_r <= FRC_W'(FULL_RST_CYC);
                    end else if (wr_cmd) begin
                        refused_r <= 1'b0;
                        viol_r <= c_viol;
                        if (!c_viol) begin
                            state_r <= ST_REQ;
                            req_r <= 1'b1;
                            wr_r <= pwdata[CMD_WRITE];
                            addr_r <= c_addr;
                            wdata_r <= c_data;
                        end
                    end
                end
                ST_REQ: begin
                    if (lnk.ack) begin
                        req_r <= 1'b0;
                        state_r <= ST_IDLE;
                        refused_r <= lnk.err;
                        rdata_r <= lnk.rdata;
                    end
                end
            endcase
        end
    end

    // range shadow follows accepted range writes and full resets
    for (genvar i = 0; i < NUM_CH; i++) begin : g_shadow
        localparam logic [LADDR_W-1:0] RA = DEV_RANGE_FIRST + LADDR_W'(i / 2);
        localparam int POS = (i % 2) * HALF_POS;
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                shadow_r[i] <= DEV_RANGE_RST[POS +: RNG_W];
            end else if (state_r == ST_RST) begin
                shadow_r[i] <= DEV_RANGE_RST[POS +: RNG_W];
            end else if (state_r == ST_REQ && lnk.ack && !lnk.err && wr_r && addr_r == RA) begin
                shadow_r[i] <= wdata_r[POS +: RNG_W];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign lnk.req = req_r;
    assign lnk.wr = wr_r;
    assign lnk.addr = addr_r;
    assign lnk.wdata = wdata_r;
    assign lnk.full_rst = state_r == ST_RST;
    assign lnk.ref_sel = ctrl_r[CTRL_REF_SEL];
    assign lnk.iface_sel = ctrl_r[CTRL_IFACE_SEL];
    assign lnk.range_pin = ctrl_r[CTRL_RANGE_PIN];
    assign lnk.os_pins = ctrl_r[CTRL_OS_LSB +: OSP_W];
endmodule : dms_host

// ===== tb/dms_props.sv
/*
 * dms_props: link checks between the host end and the device end.
 * Assumes instantiation beside the link, one clock, async low reset.
 */
`timescale 1ns/1ps
module dms_props (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic req,
    input wire logic wr,
    input wire logic [dms_pkg::LADDR_W-1:0] addr,
    input wire logic [dms_pkg::LDATA_W-1:0] wdata,
    input wire logic [dms_pkg::LDATA_W-1:0] rdata,
    input wire logic ack,
    input wire logic err,
    input wire logic full_rst,
    input wire logic iface_sel,
    input wire logic [dms_pkg::OSP_W-1:0] os_pins
);
    import dms_pkg::*;
    logic [7:0] rst_cnt_r;
    logic [7:0] rst_cnt_nxt;
    logic take;
    // a request is only taken once the full reset has dropped
    assign take = req && !ack && !full_rst;
    assign rst_cnt_nxt = full_rst ? rst_cnt_r + 8'h01 : 8'h00;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt_r <= 8'h00;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    ack_single_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (take |=> ack)
        else $error("link request not answered next cycle");
    req_hold_a: assert property (req && !ack |=> req && $stable({wr, addr, wdata}))
        else $error("link request changed before ack");
    req_release_a: assert property (ack |=> !req)
        else $error("req not dropped after ack");
    par_refuse_a: assert property (take && !iface_sel |=> err)
        else $error("register access accepted on parallel setting");
    hw_refuse_a: assert property (take && wr && os_pins != 3'b111 |=> err)
        else $error("write accepted in hardware mode");
    diag_accept_a: assert property (take && wr && iface_sel && os_pins == 3'b111
        && addr inside {[DEV_DIAG_A:DEV_DIAG_D]} |=> !err) else $error("selector write refused");
    write_rdata_a: assert property (take && wr |=> rdata == 8'h00)
        else $error("write answered with nonzero data");
    rst_quiet_a: assert property (full_rst |-> !req)
        else $error("request during full reset");
    rst_length_a: assert property ($fell(full_rst) |-> rst_cnt_r == FULL_RST_CYC)
        else $error("full reset pulse of wrong length");
endmodule : dms_props

// ===== tb/diag_mux_select_config_tb.sv
/*
 * diag_mux_select_config_tb: host and device joined by the link, host
 * driven over APB. Assumes dms_pkg, dms_link and a 100 MHz clock.
 */
`timescale 1ns/1ps
module diag_mux_select_config_tb;
    import dms_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic pready, pslverr, e;
    logic [NUM_CH*SEL_W-1:0] ch_sel;
    logic [NUM_CH-1:0] ch_ext_connect;
    logic [NUM_CH*RNG_W-1:0] ch_range;
    logic [OSR_W-1:0] os_ratio;
    logic sw_mode, serial_mode, parallel_mode, int_ref_en, diag_ref_internal;
    logic [31:0] rs = 32'h0000_0008;
    logic [2:0] sel_m [NUM_CH];
    logic [7:0] b;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    dms_link lnk_i ();
    dms_host u_dms_host (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(lnk_i.host));
    dms_device u_dms_device (.ref_clk(ref_clk), .nrst(nrst), .lnk(lnk_i.dev), .ch_sel(ch_sel),
        .ch_ext_connect(ch_ext_connect), .ch_range(ch_range), .os_ratio(os_ratio),
        .sw_mode(sw_mode),
        .serial_mode(serial_mode), .parallel_mode(parallel_mode), .int_ref_en(int_ref_en),
        .diag_ref_internal(diag_ref_internal));
    dms_props u_dms_props (.ref_clk(ref_clk), .nrst(nrst), .req(lnk_i.req), .wr(lnk_i.wr),
        .addr(lnk_i.addr), .wdata(lnk_i.wdata), .rdata(lnk_i.rdata), .ack(lnk_i.ack),
        .err(lnk_i.err), .full_rst(lnk_i.full_rst), .iface_sel(lnk_i.iface_sel),
        .os_pins(lnk_i.os_pins));
    always #5 ref_clk = ~ref_clk;
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    // expected {ext_connect, ch_sel} from the selector model
    function automatic logic [31:0] sel_exp();
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 0; i < NUM_CH; i++) begin
            v[i*SEL_W +: SEL_W] = sel_m[i];
            v[24+i] = (sel_m[i] == SEL_EXT);
        end
        return v;
    endfunction : sel_exp
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic idle_wait();
        do apb(1'b0, HR_STATUS, 32'h0000_0000); while (q[ST_BUSY] !== 1'b0);
    endtask : idle_wait
    task automatic ctrl(input logic [31:0] v);
        apb(1'b1, HR_CTRL, v);
        // pins are registered again inside the device
        repeat (2) @(posedge ref_clk);
    endtask : ctrl
    task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
        apb(1'b1, HR_CMD, {15'h0000, w, d, 2'b00, a});
        idle_wait();
    endtask : cmd
    task automatic dwrite(input int k, input logic [7:0] d);
        cmd(1'b1, DEV_DIAG_A + 6'(k), d);
        chk("accepted", q[2:0], 3'b000);
        sel_m[2*k] = d[2:0];
        sel_m[2*k+1] = d[6:4];
        chk("sel", {ch_ext_connect, ch_sel}, sel_exp());
        cmd(1'b0, DEV_DIAG_A + 6'(k), 8'h00);
        chk("readback", q[ST_RDATA_LSB +: 8], d);
    endtask : dwrite
    initial begin
        for (int i = 0; i < NUM_CH; i++) sel_m[i] = SEL_EXT;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        apb(1'b0, HR_CTRL, 32'h0000_0000);
        chk("ctrl", q, CTRL_RST);
        chk("sel", {ch_ext_connect, ch_sel}, sel_exp());
        idle_wait();
        chk("modes", {int_ref_en, diag_ref_internal, serial_mode, parallel_mode, sw_mode},
            5'h1C);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("unmapped", {e, q}, {1'b1, 32'h0000_0000});
        // every ref, interface and range pin setting; oversampling pins random below 4, never all high
        for (int m = 0; m < 8; m++) begin
            b = {1'b0, 3'(rnd()) & 3'h3, 1'b0, 3'(m)};
            ctrl({24'h00_0000, b});
            chk("ref", {int_ref_en, diag_ref_internal}, {2{b[0]}});
            chk("iface", {serial_mode, parallel_mode}, {b[1], !b[1]});
            chk("hw", {sw_mode, ch_range}, {1'b0, {8{b[2] ? RNG_10V : RNG_5V}}});
            chk("osr hw", os_ratio, {1'b0, b[6:4]});
            cmd(1'b1, DEV_DIAG_A + 6'(m & 3), (8'(rnd()) & 8'h77) | 8'h01);
            chk("hw refused", q[ST_REFUSED], 1'b1);
            chk("sel", {ch_ext_connect, ch_sel}, sel_exp());
        end
        ctrl(32'h0000_0073);
        chk("sw", {sw_mode, ch_range}, {1'b1, 32'h3333_3333});
        chk("osr sw", os_ratio, DEV_OS_RST[OSR_W-1:0]);
        for (int c = 0; c < 8; c++) dwrite(3, {1'b0, 3'(c), 1'b0, 3'(c)});
        repeat (12) dwrite(int'(rnd() & 32'h0000_0003), 8'(rnd()) & 8'h77);
        cmd(1'b1, DEV_RANGE_LAST, 8'h23);
        chk("range", ch_range[31:24], 8'h23);
        cmd(1'b1, DEV_OVERSAMPLE, 8'hA6);
        chk("osr write", {q[2:0], os_ratio}, {3'b000, 4'h6});
        cmd(1'b1, DEV_DIAG_D, 8'h10);
        chk("range guard", q[2:0], 3'b100);
        chk("sel", {ch_ext_connect, ch_sel}, sel_exp());
        dwrite(3, 8'h01);
        apb(1'b1, HR_CTRL, 32'h0000_0173);
        idle_wait();
        for (int i = 0; i < NUM_CH; i++) sel_m[i] = SEL_EXT;
        chk("sel", {ch_ext_connect, ch_sel}, sel_exp());
        chk("range", ch_range, 32'h3333_3333);
        chk("osr", os_ratio, DEV_OS_RST[OSR_W-1:0]);
        tally_and_finish();
    end
endmodule : diag_mux_select_config_tb
